// ==== design/bddma_pkg.sv ====
/*
 * Constants, field layout and state codes of the bridge DMA sequencer.
 * Assumes a single system clock; the engine, checker and bench import this.
 */
// ****************************************************************
// ****************************************************************
package bddma_pkg;
	localparam int WORD_W = 32;
	localparam int DATA_W = 64;
	localparam int ALIGN_BITS = 3;
	localparam int NUM_FLAGS = 6;

	// Transfer register select on the register write port
	localparam logic [2:0] SEL_ATTR = 3'h0;
	localparam logic [2:0] SEL_COUNT = 3'h1;
	localparam logic [2:0] SEL_VME = 3'h2;
	localparam logic [2:0] SEL_PCI = 3'h3;
	localparam logic [2:0] SEL_NEXT = 3'h4;

	// General control/status word layout
	localparam int GCS_LAUNCH = 0;
	localparam int GCS_TERM_REQ = 1;
	localparam int GCS_PAUSE_REQ = 2;
	localparam int GCS_LIST_MODE = 3;
	localparam int GCS_RUNNING = 4;
	localparam int GCS_FLAG_LSB = 8;
	localparam int GCS_IEN_LSB = 16;

	// Termination flag positions
	localparam int FLG_TERM = 0;
	localparam int FLG_PAUSED = 1;
	localparam int FLG_DONE = 2;
	localparam int FLG_PCI_ABORT = 3;
	localparam int FLG_VME_FAULT = 4;
	localparam int FLG_PROG = 5;

	// Command packet layout, word indexes
	localparam int PKT_WORDS = 8;
	localparam logic [2:0] PKT_ATTR = 3'h0;
	localparam logic [2:0] PKT_COUNT = 3'h1;
	localparam logic [2:0] PKT_VME = 3'h2;
	localparam logic [2:0] PKT_PCI = 3'h3;
	localparam logic [2:0] PKT_NEXT = 3'h4;
	localparam logic [2:0] PKT_LAST = 3'h7;
	localparam int NEXT_CONSUMED = 0;
	localparam int NEXT_END = 1;

	// Attribute bit: 1 moves PCI to VMEbus, 0 moves VMEbus to PCI
	localparam int ATTR_DIR = 31;

	// Reset values
	localparam logic [WORD_W-1:0] RST_WORD = 32'h0000_0000;
	localparam logic [NUM_FLAGS-1:0] RST_FLAGS = 6'h00;

	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_XFER = 5'b00010,
		ST_FETCH = 5'b00100,
		ST_MARK = 5'b01000,
		ST_SPARE = 5'b10000
	} bddma_state_t;
endpackage

// ==== design/bddma_pair_buf.sv ====
/*
 * Two-entry buffer with valid/ready on both sides and a flush.
 * Assumes both sides run on the same clock as the buffer.
 */
`timescale 1ns/10ps
module bddma_pair_buf #(
	parameter int W = 64
) (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic flush_i,
	// Fill side
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [W-1:0] in_data_i,
	// Drain side
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [W-1:0] out_data_o
);
	logic v0_q, v1_q;
	logic [W-1:0] d0_q, d1_q;
	logic push, pop;

	if (W < 1) begin : g_chk
		$error("bddma_pair_buf: W must be positive");
	end

	// Handshake terms
	assign in_ready_o = !v1_q;
	assign out_valid_o = v0_q;
	assign out_data_o = d0_q;
	assign push = in_valid_i && !v1_q;
	assign pop = v0_q && out_ready_i;

	// Entry storage, head in slot 0
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			v0_q <= 1'b0;
			v1_q <= 1'b0;
			d0_q <= '0;
			d1_q <= '0;
		end else if (flush_i) begin
			v0_q <= 1'b0;
			v1_q <= 1'b0;
		end else if (pop && v1_q) begin
			d0_q <= d1_q;
			v1_q <= 1'b0;
		end else if (pop) begin
			v0_q <= push;
			if (push) begin
				d0_q <= in_data_i;
			end
		end else if (push && !v0_q) begin
			d0_q <= in_data_i;
			v0_q <= 1'b1;
		end else if (push) begin
			d1_q <= in_data_i;
			v1_q <= 1'b1;
		end
	end
endmodule

// ==== design/bddma_engine.sv ====
/*
 * Bridge DMA sequencer: direct mode and linked-list mode.
 * Assumes same-clock bus arbiters, a source read port, a destination
 * write port and a packet memory port, all handshaking on clk_sys_i.
 */
`timescale 1ns/10ps
module bddma_engine #(
	parameter int DW = bddma_pkg::DATA_W
) (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// Control word write and transfer register write
	input wire logic ctl_wr_i,
	input wire logic [bddma_pkg::WORD_W-1:0] ctl_wdata_i,
	input wire logic reg_wr_i,
	input wire logic [2:0] reg_sel_i,
	input wire logic [bddma_pkg::WORD_W-1:0] reg_wdata_i,
	input wire logic pci_master_enable_i,
	// Register readback and status
	output logic [bddma_pkg::WORD_W-1:0] general_control_status_reg_o,
	output logic [bddma_pkg::WORD_W-1:0] transfer_attributes_reg_o,
	output logic [bddma_pkg::WORD_W-1:0] byte_count_remaining_o,
	output logic [bddma_pkg::WORD_W-1:0] vme_side_address_o,
	output logic [bddma_pkg::WORD_W-1:0] pci_side_address_o,
	output logic [bddma_pkg::WORD_W-1:0] next_packet_pointer_o,
	output logic engine_running_o,
	output logic irq_o,
	// Bus ownership
	output logic pci_req_o,
	input wire logic pci_gnt_i,
	output logic vme_req_o,
	input wire logic vme_gnt_i,
	// Bus errors
	input wire logic pci_abort_i,
	input wire logic vme_fault_i,
	// Source data
	output logic src_req_o,
	output logic [bddma_pkg::WORD_W-1:0] src_addr_o,
	input wire logic src_valid_i,
	input wire logic [DW-1:0] src_data_i,
	// Destination data
	output logic dst_valid_o,
	output logic [bddma_pkg::WORD_W-1:0] dst_addr_o,
	input wire logic dst_ready_i,
	output logic [DW-1:0] dst_data_o,
	// Packet memory on the PCI side
	output logic pkt_rd_o,
	output logic pkt_wr_o,
	output logic [bddma_pkg::WORD_W-1:0] pkt_addr_o,
	output logic [bddma_pkg::WORD_W-1:0] pkt_wdata_o,
	input wire logic pkt_ack_i,
	input wire logic [bddma_pkg::WORD_W-1:0] pkt_rdata_i
);
	import bddma_pkg::*;

	localparam logic [WORD_W-1:0] BEAT = WORD_W'(DW / 8);

	if (DW < 8 || DW % 8 != 0 || DW > 8 * (1 << ALIGN_BITS)) begin : g_chk
		$error("bddma_engine: DW must be whole bytes, at most 64 bits");
	end

	// ****************************************************************
	// Declarations
	// ****************************************************************
	bddma_state_t state_q, state_d;
	logic [WORD_W-1:0] attr_q, cnt_q, vaddr_q, paddr_q, npp_q, base_q;
	logic [NUM_FLAGS-1:0] flags_q, ien_q, clr, set;
	logic [2:0] idx_q;
	logic list_q, list_d, term_pend_q, pause_pend_q, skip_q, have_pkt_q;
	logic go_wr, misaligned, launch_ok, launch_bad, bus_err, idle;
	logic dir_p2v, src_gnt, dst_gnt, src_beat, dst_beat;
	logic buf_in_ready, buf_out_valid, buf_out_ready;
	logic xfer_end, fetch_last, mark_ack, enter_fetch;
	logic to_idle;

	// ****************************************************************
	// Launch decode
	// ****************************************************************
	assign idle = (state_q == ST_IDLE);
	assign clr = ctl_wr_i ? ctl_wdata_i[GCS_FLAG_LSB +: NUM_FLAGS] : '0;
	assign list_d = ctl_wr_i ? ctl_wdata_i[GCS_LIST_MODE] : list_q;
	assign go_wr = ctl_wr_i && ctl_wdata_i[GCS_LAUNCH] && idle && ((flags_q & ~clr) == '0);
	assign misaligned = (vaddr_q[ALIGN_BITS-1:0] != paddr_q[ALIGN_BITS-1:0]);
	assign launch_bad = go_wr && (!pci_master_enable_i || misaligned);
	assign launch_ok = go_wr && !launch_bad;
	assign bus_err = !idle && (pci_abort_i || vme_fault_i);

	// ****************************************************************
	// Data path and bus sharing
	// ****************************************************************
	assign dir_p2v = attr_q[ATTR_DIR];
	assign src_gnt = dir_p2v ? pci_gnt_i : vme_gnt_i;
	assign dst_gnt = dir_p2v ? vme_gnt_i : pci_gnt_i;
	assign src_req_o = (state_q == ST_XFER) && (cnt_q != '0) && !term_pend_q
		&& buf_in_ready && src_gnt;
	assign src_beat = src_req_o && src_valid_i;
	assign buf_out_ready = dst_ready_i && dst_gnt;
	assign dst_valid_o = buf_out_valid && dst_gnt;
	assign dst_beat = buf_out_valid && buf_out_ready;
	assign src_addr_o = dir_p2v ? paddr_q : vaddr_q;
	assign dst_addr_o = dir_p2v ? vaddr_q : paddr_q;

	// request whichever bus each side needs
	always_comb begin
		pci_req_o = 1'b0;
		vme_req_o = 1'b0;
		if (state_q == ST_XFER) begin
			if (dir_p2v) begin
				pci_req_o = (cnt_q != '0) && !term_pend_q;
				vme_req_o = buf_out_valid;
			end else begin
				vme_req_o = (cnt_q != '0) && !term_pend_q;
				pci_req_o = buf_out_valid;
			end
		end else if (state_q == ST_FETCH || state_q == ST_MARK) begin
			pci_req_o = 1'b1;
		end
	end

	// Two-entry buffer between source and destination
	bddma_pair_buf #(.W(DW)) u_buf (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.flush_i(bus_err),
		.in_valid_i(src_beat),
		.in_ready_o(buf_in_ready),
		.in_data_i(src_data_i),
		.out_valid_o(buf_out_valid),
		.out_ready_i(buf_out_ready),
		.out_data_o(dst_data_o)
	);

	// ****************************************************************
	// Packet memory port
	// ****************************************************************
	assign pkt_rd_o = (state_q == ST_FETCH) && pci_gnt_i;
	assign pkt_wr_o = (state_q == ST_MARK) && pci_gnt_i;
	assign pkt_addr_o = (state_q == ST_MARK) ? base_q + {27'h0, PKT_NEXT, 2'h0}
		: base_q + {27'h0, idx_q, 2'h0};
	assign pkt_wdata_o = npp_q | (WORD_W'(1) << NEXT_CONSUMED);
	assign fetch_last = pkt_rd_o && pkt_ack_i && (idx_q == PKT_LAST);
	assign mark_ack = pkt_wr_o && pkt_ack_i;
	assign xfer_end = !buf_out_valid && ((cnt_q == '0) || term_pend_q);

	// ****************************************************************
	// Sequencer
	// ****************************************************************
	always_comb begin
		state_d = state_q;
		set = '0;
		if (launch_bad) begin
			set[FLG_PROG] = 1'b1;
		end
		if (bus_err) begin
			set[FLG_PCI_ABORT] = pci_abort_i;
			set[FLG_VME_FAULT] = vme_fault_i;
			state_d = ST_IDLE;
		end else begin
			unique case (state_q)
				ST_IDLE: begin
					if (launch_ok) begin
						state_d = ST_XFER;
					end
				end
				ST_XFER: begin
					if (xfer_end) begin
						if (term_pend_q) begin
							set[FLG_TERM] = 1'b1;
							state_d = ST_IDLE;
						end else if (!list_q) begin
							set[FLG_DONE] = 1'b1;
							state_d = ST_IDLE;
						end else if (have_pkt_q && !skip_q) begin
							state_d = ST_MARK;
						end else begin
							state_d = ST_FETCH;
						end
					end
				end
				ST_FETCH: begin
					if (fetch_last) begin
						if (term_pend_q) begin
							set[FLG_TERM] = 1'b1;
							state_d = ST_IDLE;
						end else if (skip_q) begin
							state_d = ST_MARK;
						end else if (pause_pend_q) begin
							set[FLG_PAUSED] = 1'b1;
							state_d = ST_IDLE;
						end else begin
							state_d = ST_XFER;
						end
					end
				end
				ST_MARK: begin
					if (mark_ack) begin
						if (npp_q[NEXT_END]) begin
							set[FLG_DONE] = 1'b1;
							state_d = ST_IDLE;
						end else if (term_pend_q) begin
							set[FLG_TERM] = 1'b1;
							state_d = ST_IDLE;
						end else begin
							state_d = ST_FETCH;
						end
					end
				end
				default: begin
					state_d = ST_IDLE;
				end
			endcase
		end
	end

	assign to_idle = !idle && (state_d == ST_IDLE);
	assign enter_fetch = (state_d == ST_FETCH) && (state_q != ST_FETCH);

	// State register
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_q <= ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			flags_q <= RST_FLAGS;
		end else begin
			flags_q <= (flags_q & ~clr) | set;
		end
	end

	// Mode and interrupt enables
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			list_q <= 1'b0;
			ien_q <= '0;
		end else if (ctl_wr_i) begin
			list_q <= list_d;
			ien_q <= ctl_wdata_i[GCS_IEN_LSB +: NUM_FLAGS];
		end
	end

	// Pending terminate and pause requests
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			term_pend_q <= 1'b0;
			pause_pend_q <= 1'b0;
		end else if (to_idle || idle) begin
			term_pend_q <= 1'b0;
			pause_pend_q <= 1'b0;
		end else if (ctl_wr_i) begin
			term_pend_q <= term_pend_q | ctl_wdata_i[GCS_TERM_REQ];
			// pause only latched in list mode
			pause_pend_q <= pause_pend_q | (ctl_wdata_i[GCS_PAUSE_REQ] & list_q);
		end
	end

	// Packet tracking
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			skip_q <= 1'b0;
			have_pkt_q <= 1'b0;
			idx_q <= 3'h0;
			base_q <= RST_WORD;
		end else begin
			if (launch_ok) begin
				skip_q <= list_d && (cnt_q != '0) && !have_pkt_q;
				have_pkt_q <= have_pkt_q && list_d;
			end else if (reg_wr_i && idle && reg_sel_i == SEL_NEXT) begin
				have_pkt_q <= 1'b0;
			end else if (fetch_last) begin
				have_pkt_q <= 1'b1;
			end else if (mark_ack) begin
				skip_q <= 1'b0;
				have_pkt_q <= !npp_q[NEXT_END];
			end else if (bus_err) begin
				skip_q <= 1'b0;
			end
			if (enter_fetch) begin
				base_q <= {npp_q[WORD_W-1:2], 2'h0};
				idx_q <= 3'h0;
			end else if (pkt_rd_o && pkt_ack_i) begin
				idx_q <= idx_q + 3'h1;
			end
		end
	end

	// transfer registers from software, packets and beats
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			attr_q <= RST_WORD;
			cnt_q <= RST_WORD;
			vaddr_q <= RST_WORD;
			paddr_q <= RST_WORD;
			npp_q <= RST_WORD;
		end else if (idle && reg_wr_i) begin
			unique case (reg_sel_i)
				SEL_ATTR: attr_q <= reg_wdata_i;
				SEL_COUNT: cnt_q <= reg_wdata_i;
				SEL_VME: vaddr_q <= reg_wdata_i;
				SEL_PCI: paddr_q <= reg_wdata_i;
				SEL_NEXT: npp_q <= reg_wdata_i;
				default: begin
				end
			endcase
		end else if (pkt_rd_o && pkt_ack_i) begin
			if (idx_q == PKT_NEXT) begin
				npp_q <= pkt_rdata_i;
			end else if (!skip_q) begin
				if (idx_q == PKT_ATTR) attr_q <= pkt_rdata_i;
				if (idx_q == PKT_COUNT) cnt_q <= pkt_rdata_i;
				if (idx_q == PKT_VME) vaddr_q <= pkt_rdata_i;
				if (idx_q == PKT_PCI) paddr_q <= pkt_rdata_i;
			end
		end else begin
			if (src_beat) begin
				cnt_q <= (cnt_q > BEAT) ? cnt_q - BEAT : '0;
			end
			if ((src_beat && !dir_p2v) || (dst_beat && dir_p2v)) begin
				vaddr_q <= vaddr_q + BEAT;
			end
			if ((src_beat && dir_p2v) || (dst_beat && !dir_p2v)) begin
				paddr_q <= paddr_q + BEAT;
			end
		end
	end

	// ****************************************************************
	// Readback and interrupt
	// ****************************************************************
	// running follows the sequencer
	assign engine_running_o = !idle;
	assign irq_o = |(flags_q & ien_q);
	always_comb begin
		general_control_status_reg_o = '0;
		general_control_status_reg_o[GCS_LAUNCH] = 1'b0;
		general_control_status_reg_o[GCS_TERM_REQ] = term_pend_q;
		general_control_status_reg_o[GCS_PAUSE_REQ] = pause_pend_q;
		general_control_status_reg_o[GCS_LIST_MODE] = list_q;
		general_control_status_reg_o[GCS_RUNNING] = !idle;
		general_control_status_reg_o[GCS_FLAG_LSB +: NUM_FLAGS] = flags_q;
		general_control_status_reg_o[GCS_IEN_LSB +: NUM_FLAGS] = ien_q;
	end
	assign transfer_attributes_reg_o = attr_q;
	assign byte_count_remaining_o = cnt_q;
	assign vme_side_address_o = vaddr_q;
	assign pci_side_address_o = paddr_q;
	assign next_packet_pointer_o = npp_q;
endmodule

// ==== sim/bddma_engine_checker.sv ====
/*
 * Port checker of the bridge DMA sequencer.
 * Assumes binding into bddma_engine by name, one clock, async reset.
 */
`timescale 1ns/10ps
module bddma_engine_checker (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// Control side
	input wire logic ctl_wr_i,
	input wire logic [bddma_pkg::WORD_W-1:0] ctl_wdata_i,
	input wire logic pci_master_enable_i,
	input wire logic pci_gnt_i,
	input wire logic vme_gnt_i,
	// Status and data side
	input wire logic [bddma_pkg::WORD_W-1:0] general_control_status_reg_o,
	input wire logic [bddma_pkg::WORD_W-1:0] transfer_attributes_reg_o,
	input wire logic [bddma_pkg::WORD_W-1:0] vme_side_address_o,
	input wire logic [bddma_pkg::WORD_W-1:0] pci_side_address_o,
	input wire logic engine_running_o,
	input wire logic irq_o,
	input wire logic src_req_o,
	input wire logic dst_valid_o,
	input wire logic pkt_wr_o,
	input wire logic [bddma_pkg::WORD_W-1:0] pkt_addr_o,
	input wire logic [bddma_pkg::WORD_W-1:0] pkt_wdata_o
);
	import bddma_pkg::*;
	logic [5:0] flg_w;
	logic [5:0] left_w;
	logic ok_w;
	// ****************************************************************
	// Launch decode and properties
	// ****************************************************************
	assign flg_w = general_control_status_reg_o[13:8];
	assign left_w = flg_w & ~ctl_wdata_i[13:8];
	assign ok_w = pci_master_enable_i && vme_side_address_o[2:0] == pci_side_address_o[2:0];
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);
	sequence s_launch;
		ctl_wr_i && ctl_wdata_i[0] && !engine_running_o && left_w == 6'h00;
	endsequence
	property p_good_launch; s_launch ##0 ok_w |=> engine_running_o; endproperty
	a_good_launch: assert property (p_good_launch)
		else $error("valid launch did not start");
	property p_bad_launch; s_launch ##0 !ok_w |=> flg_w[5] && !engine_running_o; endproperty
	a_bad_launch: assert property (p_bad_launch)
		else $error("bad launch not refused");
	property p_launch_zero; general_control_status_reg_o[0] == 1'b0; endproperty
	a_launch_zero: assert property (p_launch_zero)
		else $error("launch bit reads one");
	property p_stop_cause; $fell(engine_running_o) |-> flg_w != 6'h00; endproperty
	a_stop_cause: assert property (p_stop_cause)
		else $error("stopped without cause flag");
	property p_hold_idle; !engine_running_o && !ctl_wr_i |=> !engine_running_o; endproperty
	a_hold_idle: assert property (p_hold_idle)
		else $error("engine started on its own");
	property p_stop_src; engine_running_o && general_control_status_reg_o[1] |-> !src_req_o; endproperty
	a_stop_src: assert property (p_stop_src)
		else $error("source active after terminate");
	property p_drained; $rose(flg_w[0]) |-> !dst_valid_o; endproperty
	a_drained: assert property (p_drained)
		else $error("terminated with data queued");
	property p_pause_list; $rose(flg_w[1]) |-> general_control_status_reg_o[3]; endproperty
	a_pause_list: assert property (p_pause_list)
		else $error("paused in direct mode");
	property p_irq; irq_o == |(flg_w & general_control_status_reg_o[21:16]); endproperty
	a_irq: assert property (p_irq)
		else $error("interrupt not cause and enable");
	property p_mark; pkt_wr_o |-> pkt_wdata_o[0] && pkt_addr_o[1:0] == 2'h0; endproperty
	a_mark: assert property (p_mark)
		else $error("packet mark without consumed bit");
	property p_src_gnt;
		src_req_o |-> (transfer_attributes_reg_o[31] ? pci_gnt_i : vme_gnt_i);
	endproperty
	a_src_gnt: assert property (p_src_gnt)
		else $error("source used without bus grant");
endmodule

// ==== sim/bddma_far_model.sv ====
/*
 * Far side of the sequencer: arbiters, source, sink, packet memory.
 * Assumes the bench loads packets with put and reads mem directly.
 */
`timescale 1ns/10ps
module bddma_far_model (
	// Clock, reset, pacing
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic slow_i,
	// Arbiters
	input wire logic pci_req_i,
	output logic pci_gnt_o,
	input wire logic vme_req_i,
	output logic vme_gnt_o,
	// Source and sink
	input wire logic src_req_i,
	input wire logic [31:0] src_addr_i,
	output logic src_valid_o,
	output logic [63:0] src_data_o,
	input wire logic dst_valid_i,
	output logic dst_ready_o,
	output logic [15:0] beats_o,
	// Packet memory
	input wire logic pkt_rd_i,
	input wire logic pkt_wr_i,
	input wire logic [31:0] pkt_addr_i,
	input wire logic [31:0] pkt_wdata_i,
	output logic pkt_ack_o,
	output logic [31:0] pkt_rdata_o
);
	// ****************************************************************
	// Behaviour
	// ****************************************************************
	logic tick_q;
	logic [31:0] mem [0:63];
	// Store a packet word
	task automatic put(input int i, input logic [31:0] w);
		mem[i] = w;
	endtask
	// Grant a cycle late, count delivered beats, mark packets
	always @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pci_gnt_o <= 1'b0;
			vme_gnt_o <= 1'b0;
			tick_q <= 1'b0;
			beats_o <= 16'h0000;
		end else begin
			pci_gnt_o <= pci_req_i;
			vme_gnt_o <= vme_req_i;
			tick_q <= ~tick_q;
			beats_o <= beats_o + 16'(dst_valid_i & dst_ready_o);
			if (pkt_wr_i && pkt_ack_o) begin
				mem[pkt_addr_i[7:2]] <= pkt_wdata_i;
			end
		end
	end
	// Slow mode answers every other cycle; idle lines keep changing
	assign src_valid_o = src_req_i & (~slow_i | ~tick_q);
	assign src_data_o = src_valid_o ? {2{src_addr_i}} : ~{2{src_addr_i}} ^ {64{tick_q}};
	assign dst_ready_o = ~slow_i | tick_q;
	assign pkt_ack_o = (pkt_rd_i | pkt_wr_i) & pci_gnt_o & (~slow_i | tick_q);
	assign pkt_rdata_o = pkt_ack_o ? mem[pkt_addr_i[7:2]] : ~mem[pkt_addr_i[7:2]];
endmodule

// ==== sim/bddma_engine_tb.sv ====
/*
 * Self-checking bench of the bridge DMA sequencer.
 * Assumes the far model and the port checker beside it.
 */
`timescale 1ns/10ps
module bddma_engine_tb;
	import bddma_pkg::*;
	// ****************************************************************
	// Signals and instances
	// ****************************************************************
	logic clk_sys_i, rst_n_i, ctl_wr_i, reg_wr_i, pci_master_enable_i, slow;
	logic [31:0] ctl_wdata_i, reg_wdata_i;
	logic [2:0] reg_sel_i;
	logic [31:0] general_control_status_reg_o, transfer_attributes_reg_o, byte_count_remaining_o;
	logic [31:0] vme_side_address_o, pci_side_address_o, next_packet_pointer_o;
	logic engine_running_o, irq_o, pci_req_o, pci_gnt_i, vme_req_o, vme_gnt_i;
	logic pci_abort_i, vme_fault_i, src_req_o, src_valid_i, dst_valid_o, dst_ready_i;
	logic pkt_rd_o, pkt_wr_o, pkt_ack_i;
	logic [31:0] src_addr_o, dst_addr_o, pkt_addr_o, pkt_wdata_o, pkt_rdata_i;
	logic [63:0] src_data_i, dst_data_o;
	logic [15:0] beats, b;
	logic [5:0] en;
	logic rev;
	logic [31:0] want;
	int bad_count, checks_done;
	bddma_engine dut (.*);
	bddma_far_model far (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .slow_i(slow),
		.pci_req_i(pci_req_o), .pci_gnt_o(pci_gnt_i), .vme_req_i(vme_req_o),
		.vme_gnt_o(vme_gnt_i), .src_req_i(src_req_o), .src_addr_i(src_addr_o),
		.src_valid_o(src_valid_i), .src_data_o(src_data_i), .dst_valid_i(dst_valid_o),
		.dst_ready_o(dst_ready_i), .beats_o(beats), .pkt_rd_i(pkt_rd_o), .pkt_wr_i(pkt_wr_o),
		.pkt_addr_i(pkt_addr_o), .pkt_wdata_i(pkt_wdata_o), .pkt_ack_o(pkt_ack_i),
		.pkt_rdata_o(pkt_rdata_i));
	// Clock
	always #50 clk_sys_i = ~clk_sys_i;
	// Delivered data carries its source address
	always @(posedge clk_sys_i) begin
		want = rev ? dst_addr_o - 32'h1000 : dst_addr_o + 32'h1000;
		if (rst_n_i && dst_valid_o && dst_ready_i) begin
			chk(dst_data_o[31:0], want);
			chk(dst_data_o[63:32], want);
		end
	end
	// ****************************************************************
	// Tasks
	// ****************************************************************
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic summarize;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic ctl(input logic [3:0] bits, input logic [5:0] clr);
		@(posedge clk_sys_i);
		ctl_wdata_i <= {10'h000, en, 2'h0, clr, 4'h0, bits};
		ctl_wr_i <= 1'b1;
		@(posedge clk_sys_i);
		ctl_wr_i <= 1'b0;
		#1;
	endtask
	task automatic wreg(input logic [2:0] sel, input logic [31:0] d);
		@(posedge clk_sys_i);
		reg_sel_i <= sel;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge clk_sys_i);
		reg_wr_i <= 1'b0;
	endtask
	task automatic prog(input logic [31:0] cnt, input logic [31:0] va, input logic [31:0] pa);
		wreg(SEL_ATTR, 32'h8000_0000);
		wreg(SEL_COUNT, cnt);
		wreg(SEL_VME, va);
		wreg(SEL_PCI, pa);
		#1;
		b = beats;
	endtask
	task automatic wait_idle;
		int n;
		n = 0;
		while (engine_running_o !== 1'b0 && n < 3000) begin
			@(posedge clk_sys_i);
			#1;
			n++;
		end
		if (engine_running_o !== 1'b0) begin
			bad_count++;
			summarize();
		end
	endtask
	// Two fresh packets at word 16 and word 32, consumed clear
	task automatic pkts;
		for (int w = 0; w < 8; w++) begin
			far.put(16 + w, w == 0 ? 32'h8000_0000 : w == 1 ? 32'h10 : w == 2 ? 32'h5000 :
				w == 3 ? 32'h6000 : w == 4 ? 32'h80 : 32'h0);
			far.put(32 + w, w == 0 ? 32'h8000_0000 : w == 1 ? 32'h8 : w == 2 ? 32'h7000 :
				w == 3 ? 32'h8000 : w == 4 ? 32'h2 : 32'h0);
		end
	endtask
	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		{clk_sys_i, rst_n_i, ctl_wr_i, reg_wr_i, pci_master_enable_i, slow} = 6'h00;
		{pci_abort_i, vme_fault_i, reg_sel_i, ctl_wdata_i, reg_wdata_i} = '0;
		{bad_count, checks_done, en, rev} = '0;
		repeat (2) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		en = 6'h3f;
		#1;
		chk(general_control_status_reg_o, 32'h0);
		for (int i = 0; i < 2; i++) begin
			pci_master_enable_i <= i[0];
			prog(32'h20, 32'h1000 | i, 32'h2000);
			ctl(4'h1, 6'h00);
			chk(engine_running_o, 1'b0);
			chk(general_control_status_reg_o[13:8], 6'h20);
			chk(irq_o, 1'b1);
			ctl(4'h0, 6'h20);
			chk(irq_o, 1'b0);
		end
		prog(32'h100, 32'h1008, 32'h2008);
		rev = 1'b1;
		wreg(SEL_ATTR, 32'h0);
		ctl(4'h1, 6'h00);
		chk(engine_running_o, 1'b1);
		ctl(4'h4, 6'h00);
		wait_idle();
		chk(general_control_status_reg_o[13:8], 6'h04);
		chk(beats - b, 32);
		chk(vme_side_address_o, 32'h1108);
		ctl(4'h1, 6'h00);
		chk(engine_running_o, 1'b0);
		repeat (5) @(posedge clk_sys_i);
		chk(engine_running_o, 1'b0);
		en = 6'h3b;
		ctl(4'h1, 6'h04);
		wait_idle();
		chk(general_control_status_reg_o[13:8], 6'h04);
		chk(irq_o, 1'b0);
		en = 6'h3f;
		{slow, rev} = 2'h2;
		prog(32'h400, 32'h0, 32'h1000);
		ctl(4'h1, 6'h04);
		repeat (10) @(posedge clk_sys_i);
		ctl(4'h2, 6'h00);
		wait_idle();
		chk(general_control_status_reg_o[13:8], 6'h01);
		chk(beats - b, (32'h400 - byte_count_remaining_o) >> 3);
		chk(byte_count_remaining_o != 32'h0, 1'b1);
		for (int i = 0; i < 2; i++) begin
			prog(32'h400, 32'h0, 32'h1000);
			ctl(4'h1, 6'h1f);
			repeat (3) @(posedge clk_sys_i);
			pci_abort_i <= i[0];
			vme_fault_i <= ~i[0];
			@(posedge clk_sys_i);
			{pci_abort_i, vme_fault_i} <= 2'h0;
			wait_idle();
			chk(general_control_status_reg_o[13:8], i ? 6'h08 : 6'h10);
		end
		slow = 1'b0;
		for (int i = 0; i < 2; i++) begin
			pkts();
			prog(i ? 32'h10 : 32'h0, 32'h0, 32'h1000);
			wreg(SEL_NEXT, 32'h40);
			ctl(4'h9, 6'h1f);
			wait_idle();
			chk(general_control_status_reg_o[13:8], 6'h04);
			chk(beats - b, 3);
			chk(far.mem[20], 32'h81);
			chk(far.mem[36], 32'h3);
			chk(vme_side_address_o, 32'h7008);
		end
		pkts();
		slow = 1'b1;
		prog(32'h0, 32'h0, 32'h0);
		wreg(SEL_NEXT, 32'h40);
		ctl(4'h9, 6'h1f);
		ctl(4'hc, 6'h00);
		wait_idle();
		chk(general_control_status_reg_o[13:8], 6'h02);
		chk(byte_count_remaining_o, 32'h10);
		chk(beats - b, 0);
		ctl(4'h9, 6'h02);
		wait_idle();
		chk(general_control_status_reg_o[13:8], 6'h04);
		chk(beats - b, 3);
		summarize();
	end
endmodule
bind bddma_engine bddma_engine_checker u_chk (.*);
